/* File: logic/ilc_flash.sv */
`timescale 1ns/1ps
`default_nettype none
module ilc_flash #(
    parameter int HALF_CYC = ilc_pkg::FLASH_HALF_CYC,
    parameter int FLASHES  = ilc_pkg::FLASH_COUNT
) (
    input  wire logic mclk,     // System clock
    input  wire logic rst,      // Async reset, active high
    input  wire logic restart,  // Start a new flash sequence
    output logic      led       // Flashing output
);
    // The phase counter is eight bits wide, so at most 127 flashes fit
    if (HALF_CYC < 1 || FLASHES < 1 || FLASHES > 127) begin : g_bad_param
        $error("ilc_flash: bad parameters");
    end

    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic [7:0]  phases;
    logic [7:0]  next_phases;
    logic        next_led;

    always_comb begin
        next_cnt    = cnt;
        next_phases = phases;
        next_led    = led;
        if (restart) begin
            next_cnt    = 32'h0;
            next_phases = 8'(2 * FLASHES);
            next_led    = 1'b1;
        end else if (phases != 8'h0) begin
            if (cnt == 32'(HALF_CYC - 1)) begin
                next_cnt    = 32'h0;
                next_phases = phases - 8'h1;
                next_led    = (phases != 8'h1) ? ~led : 1'b0;
            end else begin
                next_cnt = cnt + 32'h1;
            end
        end else begin
            next_led = 1'b0;
        end
    end

    // Flash starts at reset release and on each restart, then stays dark
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt    <= 32'h0;
            phases <= 8'(2 * FLASHES);
            led    <= 1'b1;
        end else begin
            cnt    <= next_cnt;
            phases <= next_phases;
            led    <= next_led;
        end
    end
endmodule : ilc_flash
`default_nettype wire

/* File: logic/ilc_indicator.sv */
`timescale 1ns/1ps
`default_nettype none
module ilc_indicator #(
    parameter int          FLASH_HALF = ilc_pkg::FLASH_HALF_CYC,
    parameter logic [3:0]  FW_REV     = 4'h5  // Arbitrary firmware revision low bits
) (
    input  wire logic        mclk,          // System clock
    input  wire logic        rst,           // Async reset, active high
    input  wire logic [7:0]  addr,          // Register byte address
    input  wire logic [31:0] wdata,         // Write data
    input  wire logic        wr,            // Write strobe
    input  wire logic        rd,            // Read strobe
    output logic      [31:0] rdata,         // Read data, cycle after rd
    input  wire logic        link_up,       // Host link established
    input  wire logic        link_reset,    // Host link reset pulse
    output logic      [1:0]  board_bicolor_indicator, // {red, green}
    output logic      [1:0]  chan4_indicator,         // {red, green}
    output logic      [1:0]  chan3_indicator,         // {red, green}
    output logic      [1:0]  chan2_indicator,         // {red, green}
    output logic      [1:0]  chan1_indicator,         // {red, green}
    output logic             link_state_indicator,    // Green element
    output logic             firmware_state_indicator, // Status element
    output logic             term_disable   // Internal termination off
);
    logic [31:0] board_ctrl;
    logic [31:0] pin_src;
    logic [3:0][31:0] chan_ctrl;   // Index 0 is channel 1
    logic [31:0] next_board_ctrl;
    logic [31:0] next_pin_src;
    logic [3:0][31:0] next_chan_ctrl;
    logic [31:0] next_rdata;
    logic [3:0][1:0] ind;          // Index 0 is channel 1
    // A net, so that each channel's decode may drive its own slice
    wire logic [3:0][1:0] next_ind;
    logic [1:0]  next_board_ind;
    logic        next_link_ind;
    logic        next_term;
    logic        all_zero;
    logic        flash_led;

    if (FLASH_HALF < 1) begin : g_bad_param
        $error("ilc_indicator: FLASH_HALF must be at least 1");
    end

    ilc_flash #(.HALF_CYC(FLASH_HALF), .FLASHES(ilc_pkg::FLASH_COUNT)) u_flash (
        .mclk    (mclk),
        .rst     (rst),
        .restart (link_reset),
        .led     (flash_led)
    );

    function automatic logic field_state(input logic [1:0] f, input logic cur);
        // 10 forces off, 11 forces on, other codes keep the element as it is
        if (f == ilc_pkg::FIELD_OFF)     return 1'b0;
        else if (f == ilc_pkg::FIELD_ON) return 1'b1;
        else                             return cur;
    endfunction : field_state

    always_comb begin
        next_board_ctrl = board_ctrl;
        next_pin_src    = pin_src;
        next_chan_ctrl  = chan_ctrl;
        next_rdata      = 32'h0;
        if (wr) begin
            unique case (addr)
                ilc_pkg::ADDR_BOARD_CTRL: next_board_ctrl = wdata;
                ilc_pkg::ADDR_CHAN1_CTRL: next_chan_ctrl[0] = wdata;
                ilc_pkg::ADDR_CHAN2_CTRL: next_chan_ctrl[1] = wdata;
                ilc_pkg::ADDR_CHAN3_CTRL: next_chan_ctrl[2] = wdata;
                ilc_pkg::ADDR_CHAN4_CTRL: next_chan_ctrl[3] = wdata;
                ilc_pkg::ADDR_PIN_SOURCE: next_pin_src = wdata;
                default: ;
            endcase
        end
        if (rd) begin
            unique case (addr)
                ilc_pkg::ADDR_BOARD_CTRL: next_rdata = board_ctrl;
                ilc_pkg::ADDR_CHAN1_CTRL: next_rdata = chan_ctrl[0];
                ilc_pkg::ADDR_CHAN2_CTRL: next_rdata = chan_ctrl[1];
                ilc_pkg::ADDR_CHAN3_CTRL: next_rdata = chan_ctrl[2];
                ilc_pkg::ADDR_CHAN4_CTRL: next_rdata = chan_ctrl[3];
                ilc_pkg::ADDR_PIN_SOURCE: next_rdata = pin_src;
                ilc_pkg::ADDR_LED_STATUS:
                    next_rdata = {20'h0, firmware_state_indicator, link_state_indicator,
                                  board_bicolor_indicator, ind[3], ind[2], ind[1], ind[0]};
                default: next_rdata = 32'h0;  // Unmapped reads as zero
            endcase
        end
    end

    always_comb begin
        all_zero = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (chan_ctrl[i][ilc_pkg::CH_RED_HI:ilc_pkg::CH_GREEN_LO] != 4'h0)
                all_zero = 1'b0;
        end
    end

    // Channel indicator decode, one per channel register
    for (genvar g = 0; g < 4; g++) begin : g_chan
        logic [1:0] next_chan_ind;
        always_comb begin
            next_chan_ind[1] = field_state(
                chan_ctrl[g][ilc_pkg::CH_RED_HI:ilc_pkg::CH_RED_LO], ind[g][1]);
            next_chan_ind[0] = field_state(
                chan_ctrl[g][ilc_pkg::CH_GREEN_HI:ilc_pkg::CH_GREEN_LO], ind[g][0]);
            if (all_zero) begin
                // Channel n shows revision bit n-1, so chan1 holds bit 0
                next_chan_ind = {1'b0, FW_REV[g]};
            end
        end
        assign next_ind[g] = next_chan_ind;
    end

    always_comb begin
        next_board_ind = {board_ctrl[ilc_pkg::BOARD_RED_BIT],
                          board_ctrl[ilc_pkg::BOARD_GREEN_BIT]};
        next_link_ind  = ~link_up;
        next_term      = pin_src[ilc_pkg::TERM_DIS_BIT];
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            board_ctrl               <= ilc_pkg::REG_RESET;
            pin_src                  <= ilc_pkg::REG_RESET;
            chan_ctrl                <= '0;
            rdata                    <= 32'h0;
            ind                      <= '0;
            board_bicolor_indicator  <= 2'h0;
            link_state_indicator     <= 1'b1;
            term_disable             <= 1'b0;
        end else begin
            board_ctrl               <= next_board_ctrl;
            pin_src                  <= next_pin_src;
            chan_ctrl                <= next_chan_ctrl;
            rdata                    <= next_rdata;
            ind                      <= next_ind;
            board_bicolor_indicator  <= next_board_ind;
            link_state_indicator     <= next_link_ind;
            term_disable             <= next_term;
        end
    end

    // Direct mapping: channel 1 feeds the first channel indicator, channel 4 the last
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            chan4_indicator <= 2'h0;
            chan3_indicator <= 2'h0;
            chan2_indicator <= 2'h0;
            chan1_indicator <= 2'h0;
            firmware_state_indicator <= 1'b1;
        end else begin
            chan4_indicator <= next_ind[3];
            chan3_indicator <= next_ind[2];
            chan2_indicator <= next_ind[1];
            chan1_indicator <= next_ind[0];
            firmware_state_indicator <= flash_led;
        end
    end
endmodule : ilc_indicator
`default_nettype wire

/* File: logic/ilc_pkg.sv */
`default_nettype none
package ilc_pkg;
    // Register offsets on the plain register port (byte addresses)
    localparam logic [7:0] ADDR_BOARD_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CHAN1_CTRL = 8'h04;
    localparam logic [7:0] ADDR_CHAN2_CTRL = 8'h08;
    localparam logic [7:0] ADDR_CHAN3_CTRL = 8'h0c;
    localparam logic [7:0] ADDR_CHAN4_CTRL = 8'h10;
    localparam logic [7:0] ADDR_PIN_SOURCE = 8'h14;
    localparam logic [7:0] ADDR_LED_STATUS = 8'h18;
    // Field positions
    localparam int BOARD_RED_BIT   = 25;
    localparam int BOARD_GREEN_BIT = 24;
    localparam int CH_RED_HI       = 23;
    localparam int CH_RED_LO       = 22;
    localparam int CH_GREEN_HI     = 21;
    localparam int CH_GREEN_LO     = 20;
    localparam int TERM_DIS_BIT    = 30;
    // Two-bit indicator field encoding
    localparam logic [1:0] FIELD_OFF = 2'h2;
    localparam logic [1:0] FIELD_ON  = 2'h3;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    // Firmware status flash timing
    localparam int FLASH_HALF_MS = 125;
    localparam int FLASH_COUNT   = 8;
    localparam int CLK_KHZ       = 100000;
    localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CLK_KHZ;
endpackage : ilc_pkg
`default_nettype wire

/* File: testbench/ilc_indicator_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module ilc_indicator_properties #(
    parameter logic [3:0] FW_REV = 4'h5
) (
    input wire logic        mclk,                    // Clock
    input wire logic        rst,                     // Reset
    input wire logic [7:0]  addr,                    // Address
    input wire logic [31:0] wdata,                   // Write data
    input wire logic        wr,                      // Write strobe
    input wire logic        link_up,                 // Link up
    input wire logic [1:0]  board_bicolor_indicator, // Board
    input wire logic [1:0]  chan4_indicator,         // Ch4
    input wire logic [1:0]  chan3_indicator,         // Ch3
    input wire logic [1:0]  chan2_indicator,         // Ch2
    input wire logic [1:0]  chan1_indicator,         // Ch1
    input wire logic        link_state_indicator,    // Link
    input wire logic        term_disable             // Term off
);
    wire logic       wb = wr && addr == ilc_pkg::ADDR_BOARD_CTRL;
    wire logic       wp = wr && addr == ilc_pkg::ADDR_PIN_SOURCE;
    wire logic [1:0] fr = wdata[23:22];
    wire logic [1:0] fg = wdata[21:20];
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_board_red: assert property (wb |-> ##2 board_bicolor_indicator[1] == $past(wdata[25], 2))
        else $error("board red wrong");
    a_board_green: assert property (wb |-> ##2 board_bicolor_indicator[0] == $past(wdata[24], 2))
        else $error("board green wrong");
    a_red_off: assert property (wr && addr == ilc_pkg::ADDR_CHAN1_CTRL && fr == 2'h2
        |-> ##2 !chan1_indicator[1]) else $error("red not off");
    a_red_on_rev: assert property (wr && addr == ilc_pkg::ADDR_CHAN4_CTRL && fr == 2'h3
        |-> ##2 chan4_indicator[1]) else $error("red not on");
    a_green_on: assert property (wr && addr == ilc_pkg::ADDR_CHAN2_CTRL && fg == 2'h3
        |-> ##2 chan2_indicator[0]) else $error("green not on");
    a_green_off: assert property (wr && addr == ilc_pkg::ADDR_CHAN3_CTRL && fg == 2'h2
        |-> ##2 !chan3_indicator[0]) else $error("green not off");
    a_rev_show: assert property ($past(rst, 3) && !$past(rst, 2) |-> {chan4_indicator[0],
        chan3_indicator[0], chan2_indicator[0], chan1_indicator[0]} == FW_REV)
        else $error("revision not shown");
    a_link_green: assert property (!$past(rst) |-> link_state_indicator == !$past(link_up))
        else $error("link led wrong");
    a_term_dis: assert property (wp |-> ##2 term_disable == $past(wdata[30], 2))
        else $error("termination wrong");
endmodule : ilc_indicator_properties
`default_nettype wire

/* File: testbench/test_ilc_indicator.sv */
`timescale 1ns/1ps
`default_nettype none
module test_ilc_indicator;
    logic        mclk = 0;
    logic        rst = 1;
    logic [7:0]  addr = '0;
    logic [31:0] wdata = '0;
    logic        wr = 0;
    logic        rd = 0;
    logic        link_up = 0;
    logic        link_reset = 0;
    logic [31:0] rdata;
    logic [1:0]  brd, c4, c3, c2, c1;
    logic        lnk, fw, term;
    int          mismatches = 0;
    int          num_checks = 0;
    localparam int FLASH_HALF_TB = 4;
    ilc_indicator #(.FLASH_HALF(FLASH_HALF_TB), .FW_REV(4'h5)) dut_u (.mclk(mclk), .rst(rst),
        .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link_up(link_up),
        .link_reset(link_reset), .board_bicolor_indicator(brd), .chan4_indicator(c4),
        .chan3_indicator(c3), .chan2_indicator(c2), .chan1_indicator(c1),
        .link_state_indicator(lnk), .firmware_state_indicator(fw), .term_disable(term));
    initial forever #5 mclk = ~mclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Returns after the output flop has taken the written value
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk) begin wr <= 1; addr <= a; wdata <= d; end
        @(posedge mclk) wr <= 0;
        @(posedge mclk) #1;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk) begin rd <= 1; addr <= a; end
        @(posedge mclk) rd <= 0;
        #1 chk(rdata, e);
    endtask : rd_chk
    function automatic logic [1:0] ind(input int i);
        return i == 0 ? c1 : i == 1 ? c2 : i == 2 ? c3 : c4;
    endfunction : ind
    task automatic t_board;
        wr_reg(ilc_pkg::ADDR_BOARD_CTRL, 32'h0200_0000);
        chk(brd, 2'h2);
        wr_reg(ilc_pkg::ADDR_BOARD_CTRL, 32'h0100_0000);
        chk(brd, 2'h1);
        rd_chk(ilc_pkg::ADDR_BOARD_CTRL, 32'h0100_0000);
    endtask : t_board
    task automatic t_chan;
        for (int i = 0; i < 4; i++) begin
            wr_reg(ilc_pkg::ADDR_CHAN1_CTRL + 8'(4 * i), 32'h00e0_0000);
            chk(ind(i), 2'h2);
            wr_reg(ilc_pkg::ADDR_CHAN1_CTRL + 8'(4 * i), 32'h00b0_0000);
            chk(ind(i), 2'h1);
        end
        for (int i = 0; i < 4; i++) wr_reg(ilc_pkg::ADDR_CHAN1_CTRL + 8'(4 * i), '0);
        chk({c4, c3, c2, c1}, 8'h11);
    endtask : t_chan
    task automatic t_term;
        wr_reg(ilc_pkg::ADDR_PIN_SOURCE, 32'h4000_0000);
        chk(term, 1'b1);
        wr_reg(ilc_pkg::ADDR_PIN_SOURCE, 32'hbfff_ffff);
        chk(term, 1'b0);
        wr_reg(8'h40, 32'hffff_ffff);
        rd_chk(8'h40, '0);
    endtask : t_term
    task automatic t_link_flash;
        int n;
        n = 0;
        @(posedge mclk) begin link_up <= 1; link_reset <= 1; end
        @(posedge mclk) link_reset <= 0;
        @(posedge mclk) #1 chk(lnk, 1'b0);
        // Count lit cycles: every flash is lit for one half period
        repeat (100) begin
            if (fw === 1'b1) n++;
            @(posedge mclk) #1;
        end
        chk(n, ilc_pkg::FLASH_COUNT * FLASH_HALF_TB);
        chk(fw, 1'b0);
        @(posedge mclk) link_up <= 0;
        repeat (2) @(posedge mclk);
        #1 chk(lnk, 1'b1);
    endtask : t_link_flash
    // A reset in mid-run must clear the fields and replay the power-up flash
    task automatic t_reset;
        int n;
        n = 0;
        wr_reg(ilc_pkg::ADDR_BOARD_CTRL, 32'h0300_0000);
        wr_reg(ilc_pkg::ADDR_PIN_SOURCE, 32'h4000_0000);
        wr_reg(ilc_pkg::ADDR_CHAN4_CTRL, 32'h00f0_0000);
        @(posedge mclk) rst <= 1;
        @(posedge mclk) #1 chk({brd, c4, c3, c2, c1, lnk, fw, term}, 13'h0006);
        repeat (4) @(posedge mclk);
        rst <= 0;
        repeat (100) begin
            @(posedge mclk) #1;
            if (fw === 1'b1) n++;
        end
        chk(n, ilc_pkg::FLASH_COUNT * FLASH_HALF_TB);
        chk({brd, c4, c3, c2, c1, fw, term}, 12'h044);
        rd_chk(ilc_pkg::ADDR_LED_STATUS, 32'h0000_0411);
    endtask : t_reset
    task automatic stop_test;
        $display("Checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 0;
        repeat (3) @(posedge mclk);
        #1 chk({c4, c3, c2, c1, lnk}, 9'h023);
        t_board();
        t_chan();
        t_term();
        t_link_flash();
        t_reset();
        stop_test();
    end
    initial begin
        #20000;
        mismatches++;
        stop_test();
    end
endmodule : test_ilc_indicator
bind ilc_indicator ilc_indicator_properties #(.FW_REV(FW_REV)) chk_u (.mclk(mclk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .link_up(link_up),
    .board_bicolor_indicator(board_bicolor_indicator), .chan4_indicator(chan4_indicator),
    .chan3_indicator(chan3_indicator), .chan2_indicator(chan2_indicator),
    .chan1_indicator(chan1_indicator), .link_state_indicator(link_state_indicator),
    .term_disable(term_disable));
`default_nettype wire
